//--- common/arsa_pkg.sv
// Constants and types shared by the range select and alarm flag block.
package arsa_pkg;

  // Channel count and per-variant presence masks.
  localparam int         NUM_CH      = 8;
  localparam logic [7:0] MASK_8CH    = 8'hFF;
  localparam logic [7:0] MASK_4CH    = 8'h0F;

  // Serial frame layout: address, write bit, data, MSB first.
  localparam logic [4:0] FRAME_BITS  = 5'h10;
  localparam logic [4:0] FRAME_LAST  = 5'h0F;
  localparam logic [4:0] RD_BITS     = 5'h08;
  localparam int         ADDR_MSB    = 15;
  localparam int         ADDR_LSB    = 9;
  localparam int         WR_BIT      = 8;

  // Register addresses.
  localparam logic [6:0] ADDR_FEATURE    = 7'h03;
  localparam logic [6:0] ADDR_RANGE_CH0  = 7'h05;
  localparam logic [6:0] ADDR_RANGE_CH7  = 7'h0C;
  localparam logic [6:0] ADDR_ALARM_OVW  = 7'h10;
  localparam logic [6:0] ADDR_TRIP_CH0_3 = 7'h11;
  localparam logic [6:0] ADDR_ACT_CH0_3  = 7'h12;
  localparam logic [6:0] ADDR_TRIP_CH4_7 = 7'h13;
  localparam logic [6:0] ADDR_ACT_CH4_7  = 7'h14;

  // Feature register fields.
  localparam int         FEAT_DEV_LSB  = 6;
  localparam int         FEAT_ALARM_EN = 4;
  localparam int         FEAT_FMT_LSB  = 0;
  localparam logic [2:0] FMT_WITH_RANGE = 3'h3;

  // Reset and fixed read values.
  localparam logic [3:0] RANGE_RST   = 4'h0;
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] ABSENT_READ = 8'hFF;

  // Input span selected by a range code; the code is the encoding.
  typedef enum logic [3:0] {
    SPAN_BI_2P5      = 4'b0000,
    SPAN_BI_1P25     = 4'b0001,
    SPAN_BI_0P625    = 4'b0010,
    SPAN_BI_0P3125   = 4'b0011,
    SPAN_UNI_2P5     = 4'b0101,
    SPAN_UNI_1P25    = 4'b0110,
    SPAN_UNI_0P625   = 4'b0111,
    SPAN_BI_0P15625  = 4'b1011,
    SPAN_NONE        = 4'b1111
  } arsa_span_type;

endpackage : arsa_pkg

//--- common/arsa_link_if.sv
// Request and answer between the serial link and the register core.
`timescale 1ns/1ps
interface arsa_link_if;
  logic       done;
  logic [6:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport link (output done, output addr, output wr, output wdata,
                input rdata);
  modport core (input done, input addr, input wr, input wdata,
                output rdata);
endinterface : arsa_link_if

//--- verilog/arsa_serial_link.sv
// Serial frame shifter running on the host serial clock.
`timescale 1ns/1ps
module arsa_serial_link
  import arsa_pkg::*;
(
  // Serial pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  // Toward the register core
  arsa_link_if.link lnk
);

  typedef struct packed {
    logic [4:0]  cnt;
    logic [15:0] shift;
    logic        done;
  } arsa_link_state_type;

  arsa_link_state_type st_q;
  arsa_link_state_type st_d;

  // Edges past the sixteenth are ignored until the frame closes.
  always_comb begin
    st_d = st_q;
    if (st_q.cnt != FRAME_BITS) begin
      st_d.shift = {st_q.shift[14:0], sdi};
      st_d.cnt   = st_q.cnt + 5'h01;
      st_d.done  = (st_q.cnt == FRAME_LAST);
    end
  end

  // The serial clock stops between frames, so the frame select itself
  // clears this state; the word stays steady while done is high.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Read answer of the previous frame, MSB first, one bit per edge.
  assign sdo       = (st_q.cnt < RD_BITS) ? lnk.rdata[~st_q.cnt[2:0]]
                                          : 1'b0;
  assign lnk.done  = st_q.done;
  assign lnk.addr  = st_q.shift[ADDR_MSB:ADDR_LSB];
  assign lnk.wr    = st_q.shift[WR_BIT];
  assign lnk.wdata = st_q.shift[7:0];

endmodule : arsa_serial_link

//--- verilog/arsa_range_alarm.sv
// Channel range registers and alarm flag registers behind a serial port.
`timescale 1ns/1ps
// Overview of operation
// [RQ1] Range register bits 7..4 read zero; writes there are dropped.
// [RQ2] Each channel holds a 4-bit writable range code, zero after reset.
// [RQ3] Codes 0,1,2,3,B select bipolar spans 2.5 down to 0.15625 Vref.
// [RQ4] Code 7 selects unipolar span zero to 0.625 Vref.
// [RQ5] Codes 5 and 6 select unipolar 2.5 and 1.25 Vref spans.
// [RQ6] Every channel has separate high and low flags, active and tripped.
// [RQ7] Active flag follows the threshold condition and clears by itself.
// [RQ8] Tripped flag latches the condition until its register is read.
// [RQ9] Host writes to alarm flag registers change no flag.
// [RQ10] Overview register ORs high and low tripped flags per channel.
// [RQ11] Overview bit n is channel n, one on alarm, zero after reset.
// [RQ12] Four flag registers follow the overview register.
// [RQ13] Channel 0-3 tripped register: ch0 low at bit 7 through ch3 high.
// [RQ14] Four-channel build: upper channels ignore writes and read ones.
// [RQ15] Host reads flags after the alarm pin signals an event.
// [RQ16] Read clear lands after capture; a new alarm beats the clear.
// [RQ17] Range registers sit at consecutive addresses, channel 0 first.
// [RQ18] Feature enable bit gates all alarm generation.
// [RQ19] Range-tagged format puts selected code bits 2..0 at frame end.
module arsa_range_alarm
  import arsa_pkg::*;
#(
  parameter bit EIGHT_CH = 1'b1
)
(
  // System clock and reset
  input  wire logic           clk_sys,
  input  wire logic           resetn,
  // Serial register port
  input  wire logic           sclk,
  input  wire logic           cs_n,
  input  wire logic           sdi,
  output logic                sdo,
  // Threshold comparator results
  input  wire logic [7:0]     cmp_hi_in,
  input  wire logic [7:0]     cmp_lo_in,
  // Channel in conversion
  input  wire logic [2:0]     sel_ch,
  // Front-end and output frame controls
  output arsa_span_type       span_sel,
  output logic [2:0]          range_tag,
  output logic [1:0]          dev_id,
  output logic [2:0]          out_fmt,
  output logic                alarm_en,
  output logic                alarm_pin
);

  typedef struct packed {
    logic [1:0]             sync;
    logic                   seen;
    logic [NUM_CH-1:0][3:0] range;
    logic [1:0]             dev;
    logic                   alarm_en;
    logic [2:0]             fmt;
    logic [7:0]             act_hi;
    logic [7:0]             act_lo;
    logic [7:0]             trip_hi;
    logic [7:0]             trip_lo;
    logic [7:0]             rd;
    logic                   alarm;
    logic [2:0]             tag;
    arsa_span_type          span;
  } arsa_core_state_type;

  arsa_core_state_type st_q;
  arsa_core_state_type st_d;

  arsa_link_if lnk ();

  arsa_serial_link arsa_serial_link_i (
    .sclk (sclk),
    .cs_n (cs_n),
    .sdi  (sdi),
    .sdo  (sdo),
    .lnk  (lnk.link)
  );

  localparam logic [7:0] CH_MASK = EIGHT_CH ? MASK_8CH : MASK_4CH;

  // Interleave four channels as low/high pairs, first channel on top.
  function automatic logic [7:0] pack_flags(input logic [3:0] lo,
                                            input logic [3:0] hi);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++) begin
      r[7 - 2 * i] = lo[i];
      r[6 - 2 * i] = hi[i];
    end
    return r;
  endfunction : pack_flags

  // Unlisted codes map to no span so the front end can flag them.
  function automatic arsa_span_type span_of(input logic [3:0] code);
    arsa_span_type s;
    s = SPAN_NONE;
    case (code)
      4'b0000: s = SPAN_BI_2P5;
      4'b0001: s = SPAN_BI_1P25;
      4'b0010: s = SPAN_BI_0P625;
      4'b0011: s = SPAN_BI_0P3125;
      4'b1011: s = SPAN_BI_0P15625;
      4'b0101: s = SPAN_UNI_2P5;
      4'b0110: s = SPAN_UNI_1P25;
      4'b0111: s = SPAN_UNI_0P625;
      default: s = SPAN_NONE;
    endcase
    return s;
  endfunction : span_of

  function automatic logic ch_present(input logic [2:0] ch);
    return CH_MASK[ch];
  endfunction : ch_present

  logic       acc;
  logic [7:0] rd_v;
  logic [7:0] clr;
  logic [7:0] hit_hi;
  logic [7:0] hit_lo;
  logic [2:0] idx;
  logic       in_range;

  always_comb begin
    st_d     = st_q;
    // Only the second stage may look at the first one.
    st_d.sync = {st_q.sync[0], lnk.done};
    st_d.seen = st_q.sync[1];
    acc      = st_q.sync[1] & ~st_q.seen;
    idx      = 3'(lnk.addr - ADDR_RANGE_CH0); // RQ17
    in_range = (lnk.addr >= ADDR_RANGE_CH0) &&
               (lnk.addr <= ADDR_RANGE_CH7);
    clr      = 8'h00;
    rd_v     = REG_RST;

    // Read mux; absent channels read all ones.
    if (lnk.addr == ADDR_FEATURE) begin
      rd_v = {st_q.dev, 1'b0, st_q.alarm_en, 1'b0, st_q.fmt};
    end else if (in_range) begin
      rd_v = ch_present(idx) ? {4'h0, st_q.range[idx]} // RQ1
                             : ABSENT_READ; // RQ14
    end else if (lnk.addr == ADDR_ALARM_OVW) begin
      rd_v = (st_q.trip_hi | st_q.trip_lo) | ~CH_MASK; // RQ10 RQ11
    end else if (lnk.addr == ADDR_TRIP_CH0_3) begin
      rd_v = pack_flags(st_q.trip_lo[3:0], st_q.trip_hi[3:0]); // RQ13
    end else if (lnk.addr == ADDR_ACT_CH0_3) begin
      rd_v = pack_flags(st_q.act_lo[3:0], st_q.act_hi[3:0]); // RQ12
    end else if (lnk.addr == ADDR_TRIP_CH4_7) begin
      rd_v = EIGHT_CH ? pack_flags(st_q.trip_lo[7:4], st_q.trip_hi[7:4])
                      : ABSENT_READ; // RQ12
    end else if (lnk.addr == ADDR_ACT_CH4_7) begin
      rd_v = EIGHT_CH ? pack_flags(st_q.act_lo[7:4], st_q.act_hi[7:4])
                      : ABSENT_READ; // RQ12
    end

    if (acc && lnk.wr) begin
      // Flag addresses fall through: host writes never touch flags.
      if (lnk.addr == ADDR_FEATURE) begin // RQ9
        st_d.dev      = lnk.wdata[FEAT_DEV_LSB +: 2];
        st_d.alarm_en = lnk.wdata[FEAT_ALARM_EN];
        st_d.fmt      = lnk.wdata[FEAT_FMT_LSB +: 3];
      end else if (in_range && ch_present(idx)) begin
        st_d.range[idx] = lnk.wdata[3:0]; // RQ1 RQ2 RQ14
      end
    end

    if (acc && !lnk.wr) begin
      // Answer is captured from the old flags in this same cycle.
      st_d.rd = rd_v; // RQ16
      if (lnk.addr == ADDR_TRIP_CH0_3) begin
        clr = 8'h0F; // RQ8
      end else if (lnk.addr == ADDR_TRIP_CH4_7) begin
        clr = 8'hF0; // RQ8
      end
    end

    // Threshold hits count only while the feature is enabled.
    hit_hi = st_q.alarm_en ? (cmp_hi_in & CH_MASK) : 8'h00; // RQ18
    hit_lo = st_q.alarm_en ? (cmp_lo_in & CH_MASK) : 8'h00; // RQ18
    st_d.act_hi  = hit_hi; // RQ6 RQ7
    st_d.act_lo  = hit_lo; // RQ6 RQ7
    st_d.trip_hi = (st_q.trip_hi & ~clr) | hit_hi; // RQ8 RQ16
    st_d.trip_lo = (st_q.trip_lo & ~clr) | hit_lo; // RQ8 RQ16
    st_d.alarm   = |(st_q.trip_hi | st_q.trip_lo);

    st_d.span = span_of(st_q.range[sel_ch]); // RQ3 RQ4 RQ5
    st_d.tag  = (st_q.fmt == FMT_WITH_RANGE) ? st_q.range[sel_ch][2:0]
                                             : 3'h0; // RQ19
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lnk.rdata = st_q.rd;
  assign span_sel  = st_q.span;
  assign range_tag = st_q.tag;
  assign dev_id    = st_q.dev;
  assign out_fmt   = st_q.fmt;
  assign alarm_en  = st_q.alarm_en;
  assign alarm_pin = st_q.alarm;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_read(logic [6:0] a);
    acc && !lnk.wr && (lnk.addr == a);
  endsequence

  sequence s_write(logic [6:0] a);
    acc && lnk.wr && (lnk.addr == a);
  endsequence

  a_range_upper_zero: assert property ( // RQ1
    acc && !lnk.wr && in_range && ch_present(idx) |=> st_q.rd[7:4] == 4'h0)
    else $error("Range register upper bits read nonzero.");

  a_range_write_ch0: assert property ( // RQ2
    s_write(ADDR_RANGE_CH0) |=> st_q.range[0] == $past(lnk.wdata[3:0]))
    else $error("Range code write to channel 0 lost.");

  a_span_bipolar_min: assert property ( // RQ3
    st_q.range[sel_ch] == 4'hB |=> st_q.span == SPAN_BI_0P15625)
    else $error("Code B did not select the smallest bipolar span.");

  a_span_unipolar_low: assert property ( // RQ4
    st_q.range[sel_ch] == 4'h7 |=> st_q.span == SPAN_UNI_0P625)
    else $error("Code 7 did not select the 0.625 unipolar span.");

  a_span_unipolar_wide: assert property ( // RQ5
    st_q.range[sel_ch] == 4'h5 |=> st_q.span == SPAN_UNI_2P5)
    else $error("Code 5 did not select the 2.5 unipolar span.");

  a_active_follows: assert property ( // RQ7
    st_q.alarm_en && cmp_lo_in[5] ##1 !cmp_lo_in[5]
      |=> !st_q.act_lo[5])
    else $error("Active flag did not clear with its condition.");

  a_trip_latched: assert property ( // RQ8
    st_q.trip_hi[2] &&
      !(acc && !lnk.wr && (lnk.addr == ADDR_TRIP_CH0_3))
      |=> st_q.trip_hi[2])
    else $error("Tripped flag cleared without a read.");

  a_flag_write_kept: assert property ( // RQ9
    s_write(ADDR_TRIP_CH0_3) |=>
      (($past(st_q.trip_lo) & ~st_q.trip_lo) == 8'h00))
    else $error("Write to a flag register cleared a flag.");

  a_overview_or: assert property ( // RQ10
    s_read(ADDR_ALARM_OVW) |=>
      st_q.rd == ($past(st_q.trip_hi | st_q.trip_lo) | ~CH_MASK))
    else $error("Overview read is not the OR of tripped flags.");

  a_read_order: assert property ( // RQ13
    s_read(ADDR_TRIP_CH0_3) |=>
      st_q.rd[7] == $past(st_q.trip_lo[0]) &&
      st_q.rd[0] == $past(st_q.trip_hi[3]))
    else $error("Tripped register bit order is wrong.");

  a_read_clears: assert property ( // RQ16
    s_read(ADDR_TRIP_CH0_3) ##0 (!cmp_lo_in[2] && !cmp_hi_in[2])
      |=> !st_q.trip_lo[2] && !st_q.trip_hi[2])
    else $error("Read did not clear the tripped flags.");

  a_set_wins: assert property ( // RQ16
    s_read(ADDR_TRIP_CH0_3) ##0 (st_q.alarm_en && cmp_hi_in[3])
      |=> st_q.trip_hi[3])
    else $error("New alarm lost to a read clear.");

  a_absent_ones: assert property ( // RQ14
    s_read(ADDR_TRIP_CH4_7) |=> (EIGHT_CH || (st_q.rd == ABSENT_READ)))
    else $error("Absent register did not read all ones.");

  a_alarm_gated: assert property ( // RQ18
    !st_q.alarm_en |=> st_q.act_hi == 8'h00 && st_q.act_lo == 8'h00)
    else $error("Active flag set while alarms disabled.");

  a_range_tag: assert property ( // RQ19
    st_q.fmt == FMT_WITH_RANGE |=>
      st_q.tag == $past(st_q.range[sel_ch][2:0]))
    else $error("Range tag does not match selected channel code.");

endmodule : arsa_range_alarm

//--- dv/arsa_host_model.sv
// Serial host model that frames register accesses for the range block.
`timescale 1ns/1ps
module arsa_host_model (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  localparam time HALF = 3ns;

  // The serial clock stands low outside frames. The link state has no
  // reset but a rising select, so select is raised once after time zero.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    sdi  = 1'b1;
    #2ns;
    cs_n = 1'b1;
  end

  // One frame; rx returns what the previous read frame left on sdo.
  task automatic xfer(input logic [6:0] addr, input logic wr,
                      input logic [7:0] data, output logic [7:0] rx);
    logic [15:0] word;
    word = {addr, wr, data};
    cs_n = 1'b0;
    sdi  = word[15];
    #(HALF);
    rx[7] = sdo;
    for (int k = 1; k <= 16; k++) begin
      sclk = 1'b1;
      #(HALF);
      sclk = 1'b0;
      if (k <= 7) rx[7-k] = sdo;
      if (k < 16) sdi = word[15-k];
      #(HALF);
    end
    // The core needs a few system clocks to act before select drops.
    #60ns;
    cs_n = 1'b1;
    sdi  = ~sdi;
    #30ns;
  endtask : xfer
endmodule : arsa_host_model

//--- dv/arsa_range_alarm_tb_top.sv
// Self-checking bench for the range select and alarm flag block.
`timescale 1ns/1ps
module arsa_range_alarm_tb_top;
  import arsa_pkg::*;
  logic          clk_sys, resetn, sclk, cs_n, sdi;
  logic          sdo8, sdo4, use4, alarm_en, alarm_pin;
  logic [7:0]    cmp_hi_in, cmp_lo_in;
  logic [2:0]    sel_ch, range_tag, out_fmt;
  logic [1:0]    dev_id;
  arsa_span_type span_sel;
  int            fail_count = 0;
  int            n_tests = 0;
  arsa_span_type spans [8] = '{SPAN_BI_2P5, SPAN_BI_1P25, SPAN_BI_0P625,
    SPAN_BI_0P3125, SPAN_BI_0P15625, SPAN_UNI_2P5, SPAN_UNI_1P25,
    SPAN_UNI_0P625};

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  arsa_host_model arsa_host_model_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(use4 ? sdo4 : sdo8));
  arsa_range_alarm #(.EIGHT_CH(1'b1)) arsa_range_alarm_i (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo8), .cmp_hi_in(cmp_hi_in), .cmp_lo_in(cmp_lo_in),
    .sel_ch(sel_ch), .span_sel(span_sel), .range_tag(range_tag),
    .dev_id(dev_id), .out_fmt(out_fmt), .alarm_en(alarm_en),
    .alarm_pin(alarm_pin));
  // The four-channel build shares every input; only its sdo is watched.
  arsa_range_alarm #(.EIGHT_CH(1'b0)) arsa_range_alarm_4ch_i (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .sdo(sdo4), .cmp_hi_in(cmp_hi_in), .cmp_lo_in(cmp_lo_in),
    .sel_ch(sel_ch), .span_sel(), .range_tag(), .dev_id(), .out_fmt(),
    .alarm_en(), .alarm_pin());

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_clk

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    arsa_host_model_i.xfer(a, 1'b1, d, rx);
    // Realign so that later stimulus lands just after a system edge.
    wait_clk(1);
  endtask : wr_reg

  // A read answer only leaves the device in the frame that follows.
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    arsa_host_model_i.xfer(a, 1'b0, 8'h00, rx);
    arsa_host_model_i.xfer(7'h7F, 1'b0, 8'h00, rx);
    wait_clk(1);
    check(rx, exp);
  endtask : rd_chk

  task automatic t_reset;
    check({4'h0, span_sel}, {4'h0, SPAN_BI_2P5});
    check({7'h00, alarm_pin}, 8'h00);
    rd_chk(ADDR_RANGE_CH7, REG_RST);
    rd_chk(ADDR_ALARM_OVW, REG_RST);
    rd_chk(ADDR_TRIP_CH0_3, REG_RST);
  endtask : t_reset

  // The host keeps the reserved upper nibble at zero on every range register write.
  task automatic t_ranges;
    for (int ch = 0; ch < 8; ch++) begin
      wr_reg(ADDR_RANGE_CH0 + 7'(ch), {4'h0, spans[ch]});
    end
    wr_reg(ADDR_FEATURE, 8'hD3);
    wait_clk(2);
    check({7'h00, alarm_en}, 8'h01);
    check({6'h00, dev_id}, 8'h03);
    check({5'h00, out_fmt}, {5'h00, FMT_WITH_RANGE});
    rd_chk(ADDR_FEATURE, 8'hD3);
    for (int ch = 0; ch < 8; ch++) begin
      rd_chk(ADDR_RANGE_CH0 + 7'(ch), {4'h0, spans[ch]});
      sel_ch = 3'(ch);
      wait_clk(3);
      check({4'h0, span_sel}, {4'h0, spans[ch]});
      check({5'h00, range_tag}, {5'h00, spans[ch][2:0]});
    end
    use4 = 1'b1;
    rd_chk(ADDR_RANGE_CH0 + 7'h04, ABSENT_READ);
    rd_chk(ADDR_RANGE_CH0 + 7'h03, {4'h0, spans[3]});
    use4 = 1'b0;
  endtask : t_ranges

  task automatic t_alarm;
    int n;
    cmp_hi_in[2] = 1'b1;
    cmp_lo_in[5] = 1'b1;
    n = 0;
    while (alarm_pin !== 1'b1 && n < 20) begin
      wait_clk(1);
      n++;
    end
    check({7'h00, alarm_pin}, 8'h01);
    rd_chk(ADDR_ACT_CH0_3, 8'h04);
    rd_chk(ADDR_ACT_CH4_7, 8'h20);
    cmp_hi_in[2] = 1'b0;
    cmp_lo_in[5] = 1'b0;
    wait_clk(3);
    wr_reg(ADDR_TRIP_CH0_3, 8'h00);
    wr_reg(ADDR_ALARM_OVW, 8'h00);
    rd_chk(ADDR_ACT_CH0_3, 8'h00);
    rd_chk(ADDR_ALARM_OVW, 8'h24);
    // Both builds see every frame, so the upper read goes first here.
    rd_chk(ADDR_TRIP_CH4_7, 8'h20);
    use4 = 1'b1;
    rd_chk(ADDR_ALARM_OVW, 8'hF4);
    rd_chk(ADDR_TRIP_CH4_7, ABSENT_READ);
    use4 = 1'b0;
    rd_chk(ADDR_TRIP_CH0_3, 8'h04);
    rd_chk(ADDR_TRIP_CH0_3, 8'h00);
    rd_chk(ADDR_ALARM_OVW, 8'h00);
    wait_clk(3);
    check({7'h00, alarm_pin}, 8'h00);
  endtask : t_alarm

  // A hit present while the flag is read keeps the flag set.
  task automatic t_set_wins;
    cmp_hi_in[3] = 1'b1;
    wait_clk(2);
    rd_chk(ADDR_TRIP_CH0_3, 8'h01);
    rd_chk(ADDR_TRIP_CH0_3, 8'h01);
    cmp_hi_in[3] = 1'b0;
    wait_clk(2);
    rd_chk(ADDR_TRIP_CH0_3, 8'h01);
    rd_chk(ADDR_TRIP_CH0_3, 8'h00);
  endtask : t_set_wins

  task automatic t_disabled;
    wr_reg(ADDR_FEATURE, 8'h00);
    cmp_hi_in = 8'hFF;
    wait_clk(4);
    check({7'h00, alarm_en}, 8'h00);
    check({7'h00, alarm_pin}, 8'h00);
    check({5'h00, range_tag}, 8'h00);
    check({5'h00, out_fmt}, 8'h00);
    rd_chk(ADDR_ALARM_OVW, 8'h00);
    cmp_hi_in = 8'h00;
  endtask : t_disabled

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  initial begin
    resetn    = 1'b0;
    use4      = 1'b0;
    cmp_hi_in = 8'h00;
    cmp_lo_in = 8'h00;
    sel_ch    = 3'h0;
    wait_clk(4);
    resetn = 1'b1;
    wait_clk(3);
    t_reset();
    t_ranges();
    t_alarm();
    t_set_wins();
    t_disabled();
    finish_test();
  end

  // Whole run needs well under 40 us; a hang is cut off far beyond that.
  initial begin
    #200us;
    fail_count++;
    finish_test();
  end
endmodule : arsa_range_alarm_tb_top
